/* hdl/sms_pkg.sv */
// Purpose: Constants, types and register map of the standby mode sequencer.
// Assumes: 16-bit register addresses with 8-bit data, as a plain strobe port.
// Notes:   Register bits that do not exist read as one.
package sms_pkg;

    localparam int         ADDR_W           = 16;
    localparam int         DATA_W           = 8;

    // Register offsets
    localparam logic [15:0] PWR_MODE_OFS    = 16'hfe07;
    localparam logic [15:0] WDG_CTRL_OFS    = 16'hfe0f;
    localparam logic [15:0] WDG_CNT_OFS     = 16'hfe79;
    localparam logic [15:0] OSC_PRI_OFS     = 16'hfe0e;
    localparam logic [15:0] OSC_SEC_OFS     = 16'hfe0d;

    // Values after reset
    localparam logic [2:0] PWR_MODE_RST     = 3'h0;
    localparam logic [7:0] WDG_CTRL_RST     = 8'h00;
    localparam logic [7:0] WDG_CNT_RST      = 8'h00;
    localparam logic [7:0] OSC_PRI_RST      = 8'h01;
    localparam logic [7:0] OSC_SEC_RST      = 8'h00;
    localparam logic [4:0] PWR_MODE_UNUSED  = 5'h1f;
    localparam logic [7:0] UNMAPPED_READ    = 8'hff;

    // Field positions
    localparam int         HALT_BIT         = 0;
    localparam int         HOLD_BIT         = 1;
    localparam int         XHOLD_BIT        = 2;
    localparam int         WDG_ARM_BIT      = 4;
    localparam logic [7:0] WDG_CLR_MASK     = 8'h07;
    localparam int         CNT_RUN_BIT      = 5;
    localparam int         CNT_SEL_HI_BIT   = 4;
    localparam int         CNT_SEL_LO_BIT   = 3;
    localparam logic [7:0] PRI_CLR_WIDE     = 8'h32;
    localparam logic [7:0] PRI_CLR_NARROW   = 8'h30;
    localparam int         SEC_SEL_BIT      = 1;
    localparam int         SEC_SET_BIT      = 0;
    localparam int         MAIN_OSC_BIT     = 0;

    typedef enum logic [3:0] {
        SMS_NORMAL = 4'h1,
        SMS_HALT   = 4'h2,
        SMS_HOLD   = 4'h4,
        SMS_XHOLD  = 4'h8
    } sms_mode_e;

    typedef struct packed {
        logic [2:0] powerModeControl;
        logic [7:0] watchdogControl;
        logic [7:0] watchdogCountControl;
        logic [7:0] primaryOscillatorControl;
        logic [7:0] secondaryOscillatorControl;
    } sms_regs_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sms_bus_s;

    typedef struct packed {
        sms_mode_e         mode;
        sms_regs_s         regs;
        logic [DATA_W-1:0] rdata;
        logic              mainOscRun;
        logic              entryPulse;
        logic              wakePulse;
    } sms_state_s;

endpackage

/* hdl/sms_entry_effects.sv */
// Purpose: Register side effects applied on entry to a standby mode.
// Assumes: Called only in the cycle in which software requests the entry.
// Notes:   Pure combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module sms_entry_effects
    import sms_pkg::*;
(
    // Request
    input  wire logic      enter,
    input  wire sms_mode_e target,
    // Registers in and out
    input  wire sms_regs_s regsIn,
    output var  sms_regs_s regsOut
);
    import sms_pkg::*;

    always_comb begin
        regsOut = regsIn;
        if (enter && target != SMS_NORMAL) begin
            if (regsIn.watchdogControl[WDG_ARM_BIT]) begin
                regsOut.watchdogControl = regsIn.watchdogControl & ~WDG_CLR_MASK;
            end
            if (!regsIn.watchdogCountControl[CNT_SEL_HI_BIT]
                && regsIn.watchdogCountControl[CNT_SEL_LO_BIT]) begin
                regsOut.watchdogCountControl[CNT_RUN_BIT] = 1'b0;
            end
            if (target == SMS_HOLD || target == SMS_XHOLD) begin
                regsOut.powerModeControl[HALT_BIT] = 1'b1;
            end
            // Crystal HOLD leaves both oscillator registers alone
            if (target == SMS_HOLD) begin
                if (regsIn.secondaryOscillatorControl[SEC_SEL_BIT]) begin
                    regsOut.secondaryOscillatorControl[SEC_SET_BIT] = 1'b1;
                    regsOut.primaryOscillatorControl =
                        regsIn.primaryOscillatorControl & ~PRI_CLR_NARROW;
                end else begin
                    regsOut.primaryOscillatorControl =
                        regsIn.primaryOscillatorControl & ~PRI_CLR_WIDE;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* hdl/sms_standby_sequencer.sv */
// Purpose: Standby mode sequencer: HALT, HOLD and crystal HOLD with entry effects.
// Assumes: All inputs synchronous to sys_clk; reset sources are active-high levels.
// Notes:   Read data appear one cycle after the read strobe; no wait states.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module sms_standby_sequencer
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Reset sources
    input  wire logic                      externalResetPin,
    input  wire logic                      powerOnReset,
    input  wire logic                      watchdogReset,
    // Wake events
    input  wire logic                      interruptAccept,
    input  wire logic                      holdRelease,
    // Register port
    input  wire logic [sms_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [sms_pkg::DATA_W-1:0] regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [sms_pkg::DATA_W-1:0] regRdata,
    // Status
    output logic      [3:0]                modeOneHot,
    output logic                           cpuRun,
    output logic                           mainOscRun,
    output logic                           standbyEntry,
    output logic                           standbyWake,
    output logic                           inResetState
);
    import sms_pkg::*;

    sms_state_s state_q;
    sms_state_s state_d;
    sms_regs_s  regsWritten;
    sms_regs_s  regsEffect;
    sms_mode_e  target;
    logic       enterReq;
    logic       anyReset;
    logic       inReset_q;
    logic       cpuRun_q;
    sms_bus_s   bus;

    ////////////////////////////////////////////////////////////////////////

    function automatic sms_mode_e decode_mode(input logic [2:0] pm);
        if (pm[HOLD_BIT] && pm[XHOLD_BIT]) begin
            decode_mode = SMS_XHOLD;
        end else if (pm[HOLD_BIT]) begin
            decode_mode = SMS_HOLD;
        end else if (pm[HALT_BIT]) begin
            decode_mode = SMS_HALT;
        end else begin
            decode_mode = SMS_NORMAL;
        end
    endfunction

    function automatic logic [7:0] read_reg(input sms_regs_s r, input logic [15:0] a);
        case (a)
            PWR_MODE_OFS: read_reg = {PWR_MODE_UNUSED, r.powerModeControl};
            WDG_CTRL_OFS: read_reg = r.watchdogControl;
            WDG_CNT_OFS:  read_reg = r.watchdogCountControl;
            OSC_PRI_OFS:  read_reg = r.primaryOscillatorControl;
            OSC_SEC_OFS:  read_reg = r.secondaryOscillatorControl;
            default:      read_reg = UNMAPPED_READ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////

    assign anyReset = reset || externalResetPin || powerOnReset || watchdogReset;
    assign bus      = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Hardware clears first, software write last: a write that sets a flag wins
    always_comb begin
        regsWritten = state_q.regs;
        if (state_q.mode == SMS_HOLD || state_q.mode == SMS_XHOLD) begin
            if (holdRelease) begin
                regsWritten.powerModeControl[HOLD_BIT] = 1'b0;
            end
        end else if (interruptAccept && state_q.mode == SMS_HALT) begin
            regsWritten.powerModeControl[HALT_BIT] = 1'b0;
        end
        enterReq = 1'b0;
        if (bus.wr) begin
            case (bus.addr)
                PWR_MODE_OFS: begin
                    regsWritten.powerModeControl = bus.wdata[2:0];
                    enterReq = bus.wdata[HALT_BIT] || bus.wdata[HOLD_BIT];
                end
                WDG_CTRL_OFS: regsWritten.watchdogControl = bus.wdata;
                WDG_CNT_OFS:  regsWritten.watchdogCountControl = bus.wdata;
                OSC_PRI_OFS:  regsWritten.primaryOscillatorControl = bus.wdata;
                OSC_SEC_OFS:  regsWritten.secondaryOscillatorControl = bus.wdata;
                default:      enterReq = 1'b0;
            endcase
        end
        target = decode_mode(regsWritten.powerModeControl);
        // Only a software request counts as entry; falling back from HOLD does not
        enterReq = enterReq && (target != state_q.mode) && (target != SMS_NORMAL);
    end

    sms_entry_effects u_entry (
        .enter   (enterReq),
        .target  (target),
        .regsIn  (regsWritten),
        .regsOut (regsEffect)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        state_d            = state_q;
        state_d.regs       = regsEffect;
        state_d.mode       = decode_mode(regsEffect.powerModeControl);
        state_d.entryPulse = enterReq;
        state_d.wakePulse  = (state_q.mode != SMS_NORMAL)
                             && (decode_mode(regsEffect.powerModeControl) == SMS_NORMAL);
        state_d.rdata      = bus.rd ? read_reg(state_q.regs, bus.addr) : '0;
        case (state_d.mode)
            SMS_NORMAL: state_d.mainOscRun = regsEffect.primaryOscillatorControl[MAIN_OSC_BIT];
            SMS_HALT:   state_d.mainOscRun = state_q.mainOscRun;
            SMS_HOLD:   state_d.mainOscRun = 1'b0;
            SMS_XHOLD:  state_d.mainOscRun = 1'b0;
            default:    state_d.mainOscRun = 1'b1;
        endcase
        if (anyReset) begin
            state_d.mode       = SMS_NORMAL;
            state_d.regs       = '{PWR_MODE_RST, WDG_CTRL_RST, WDG_CNT_RST,
                                   OSC_PRI_RST, OSC_SEC_RST};
            state_d.rdata      = '0;
            state_d.mainOscRun = 1'b1;
            state_d.entryPulse = 1'b0;
            state_d.wakePulse  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_q   <= state_d;
        inReset_q <= anyReset;
        // Registered so the run flag leaves the block straight from a flop
        cpuRun_q  <= (state_d.mode == SMS_NORMAL);
    end

    ////////////////////////////////////////////////////////////////////////

    assign regRdata     = state_q.rdata;
    assign modeOneHot   = state_q.mode;
    assign cpuRun       = cpuRun_q;
    assign mainOscRun   = state_q.mainOscRun;
    assign standbyEntry = state_q.entryPulse;
    assign standbyWake  = state_q.wakePulse;
    assign inResetState = inReset_q;

endmodule
`default_nettype wire

/* tb/sms_standby_sequencer_assertions.sv */
// Purpose: Port checker for the standby mode sequencer.
// Assumes: Any of the four reset sources resets the block.
// Notes:   Bound into every sequencer instance.
`timescale 1ns/100ps
`default_nettype none
module sms_standby_sequencer_assertions
    import sms_pkg::*;
(
    // Clock and resets
    input wire logic        sys_clk, reset, externalResetPin, powerOnReset, watchdogReset,
    // Requests
    input wire logic        interruptAccept, holdRelease, regWr,
    input wire logic [15:0] regAddr,
    input wire logic [7:0]  regWdata,
    // Status
    input wire logic [3:0]  modeOneHot,
    input wire logic        cpuRun, mainOscRun, standbyEntry, standbyWake, inResetState
);
    wire anyRst = reset | externalResetPin | powerOnReset | watchdogReset;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (anyRst);
    a_mode_onehot: assert property ($onehot(modeOneHot)) else $error("mode not one-hot");
    a_cpu_normal: assert property (cpuRun == (modeOneHot == 4'h1)) else $error("cpuRun");
    a_hold_osc: assert property (modeOneHot[2] | modeOneHot[3] |-> !mainOscRun)
        else $error("oscillator runs in hold");
    a_halt_osc_keep: assert property (modeOneHot == 4'h2 && $past(modeOneHot) == 4'h2
        |-> $stable(mainOscRun)) else $error("oscillator changed in halt");
    a_entry_cause: assert property (standbyEntry |-> $past(regWr) && !cpuRun
        && $past(regAddr) == PWR_MODE_OFS) else $error("entry pulse without write");
    a_xhold_enter: assert property (regWr && regAddr == PWR_MODE_OFS && cpuRun
        && regWdata[2:1] == 2'h3 |=> modeOneHot == 4'h8) else $error("no crystal hold");
    a_release_halt: assert property ((modeOneHot[2] | modeOneHot[3]) && holdRelease
        && !(regWr && regAddr == PWR_MODE_OFS) |=> modeOneHot == 4'h2)
        else $error("release did not reach halt");
    a_irq_wake: assert property (modeOneHot == 4'h2 && interruptAccept && !regWr
        |=> cpuRun ##0 standbyWake) else $error("no wake on interrupt");
    a_reset_init: assert property (disable iff (1'b0) anyRst
        |=> cpuRun && mainOscRun && inResetState && !standbyEntry) else $error("reset state");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sms_standby_sequencer sms_standby_sequencer_assertions chk (.sys_clk, .reset,
    .externalResetPin, .powerOnReset, .watchdogReset, .interruptAccept, .holdRelease,
    .regWr, .regAddr, .regWdata, .modeOneHot, .cpuRun, .mainOscRun, .standbyEntry,
    .standbyWake, .inResetState);
`default_nettype wire

/* tb/tb_sms_standby_sequencer.sv */
// Purpose: Self-checking bench for the standby mode sequencer.
// Assumes: 50 MHz clock, synchronous reset held four cycles.
// Notes:   Scenarios build on register contents left by the one before.
`timescale 1ns/100ps
`default_nettype none
module tb_sms_standby_sequencer;
    import sms_pkg::*;
    logic        sys_clk, reset, externalResetPin, powerOnReset, watchdogReset;
    logic        interruptAccept, holdRelease, regWr, regRd;
    logic [15:0] regAddr;
    logic [7:0]  regWdata, regRdata;
    logic [3:0]  modeOneHot;
    logic        cpuRun, mainOscRun, standbyEntry, standbyWake, inResetState;
    int          error_cnt = 0;
    int          comparisons = 0;
    sms_standby_sequencer DUT (.sys_clk, .reset, .externalResetPin, .powerOnReset,
        .watchdogReset, .interruptAccept, .holdRelease, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .modeOneHot, .cpuRun, .mainOscRun, .standbyEntry,
        .standbyWake, .inResetState);
    initial begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic md(input logic [3:0] e);
        chk("mode", {4'h0, modeOneHot}, {4'h0, e});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk(n, regRdata, e);
    endtask
    // One-cycle pulse: 0 irq, 1 release, 2..5 the reset sources
    task automatic pulse(input int k);
        @(posedge sys_clk);
        {reset, watchdogReset, powerOnReset, externalResetPin, holdRelease,
            interruptAccept} <= 6'h01 << k;
        @(posedge sys_clk);
        {reset, watchdogReset, powerOnReset, externalResetPin, holdRelease,
            interruptAccept} <= 6'h00;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rd("power", PWR_MODE_OFS, 8'hf8);
        rd("wdg", WDG_CTRL_OFS, 8'h00);
        rd("count", WDG_CNT_OFS, 8'h00);
        rd("primary", OSC_PRI_OFS, 8'h01);
        rd("secondary", OSC_SEC_OFS, 8'h00);
        rd("unmapped", 16'hfe00, 8'hff);
        chk("osc", mainOscRun, 8'h01);
    endtask
    task automatic t_halt;
        wr(WDG_CTRL_OFS, 8'h17);
        wr(WDG_CNT_OFS, 8'h28);
        wr(OSC_PRI_OFS, 8'h33);
        wr(PWR_MODE_OFS, 8'h01);
        md(4'h2);
        chk("cpu", cpuRun, 8'h00);
        chk("entry", standbyEntry, 8'h01);
        rd("wdg", WDG_CTRL_OFS, 8'h10);
        rd("count", WDG_CNT_OFS, 8'h08);
        rd("primary", OSC_PRI_OFS, 8'h33);
        chk("osc", mainOscRun, 8'h01);
        pulse(0);
        md(4'h1);
        chk("wake", standbyWake, 8'h01);
        chk("cpu", cpuRun, 8'h01);
        rd("power", PWR_MODE_OFS, 8'hf8);
    endtask
    // Watchdog fields chosen so that neither clear condition holds
    task automatic t_hold(input logic [7:0] sec, input logic [7:0] pri, input logic [7:0] sx);
        wr(OSC_SEC_OFS, sec);
        wr(OSC_PRI_OFS, 8'h33);
        wr(WDG_CTRL_OFS, 8'h07);
        wr(WDG_CNT_OFS, 8'h38);
        wr(PWR_MODE_OFS, 8'h02);
        md(4'h4);
        chk("osc", mainOscRun, 8'h00);
        rd("power", PWR_MODE_OFS, 8'hfb);
        rd("primary", OSC_PRI_OFS, pri);
        rd("secondary", OSC_SEC_OFS, sx);
        rd("wdg", WDG_CTRL_OFS, 8'h07);
        rd("count", WDG_CNT_OFS, 8'h38);
        pulse(1);
        md(4'h2);
        chk("osc", mainOscRun, 8'h00);
        rd("power", PWR_MODE_OFS, 8'hf9);
        pulse(0);
        md(4'h1);
    endtask
    task automatic t_xhold;
        wr(PWR_MODE_OFS, 8'h06);
        md(4'h8);
        chk("osc", mainOscRun, 8'h00);
        rd("power", PWR_MODE_OFS, 8'hff);
        rd("primary", OSC_PRI_OFS, 8'h03);
        pulse(1);
        md(4'h2);
        rd("power", PWR_MODE_OFS, 8'hfd);
        pulse(0);
        md(4'h1);
        wr(PWR_MODE_OFS, 8'h00);
    endtask
    task automatic t_resets;
        for (int k = 2; k < 6; k++) begin
            wr(WDG_CTRL_OFS, 8'h55);
            wr(PWR_MODE_OFS, 8'h02);
            pulse(k);
            md(4'h1);
            chk("in reset", inResetState, 8'h01);
            rd("wdg", WDG_CTRL_OFS, 8'h00);
            rd("power", PWR_MODE_OFS, 8'hf8);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {reset, watchdogReset, powerOnReset, externalResetPin, holdRelease,
            interruptAccept} = 6'h20;
        {regWr, regRd, regAddr, regWdata} = '0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
        t_halt();
        t_hold(8'h00, 8'h01, 8'h00);
        t_hold(8'h02, 8'h03, 8'h03);
        t_xhold();
        t_resets();
        end_sim();
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
